// [core/spfs_defines.vh]
// Constants for the soft-pin frequency scale register section.
// Assumes a 32-bit APB register bus and a 250 MHz system clock.
`ifndef SPFS_DEFINES_VH
`define SPFS_DEFINES_VH

// Register indices; the byte address on APB is four times the index.
`define SPFS_IDX_ENABLE      12'h0C03
`define SPFS_IDX_REF_SCALE   12'h0C04
`define SPFS_IDX_OUT_SCALE   12'h0C05
`define SPFS_IDX_APPLIED     12'h0C09

// Byte addresses seen on paddr.
`define SPFS_ADDR_ENABLE     16'h300C
`define SPFS_ADDR_REF_SCALE  16'h3010
`define SPFS_ADDR_OUT_SCALE  16'h3014
`define SPFS_ADDR_APPLIED    16'h3024
`define SPFS_ADDR_W          16

// Field positions.
`define SPFS_ENABLE_BIT      0
`define SPFS_FIELD_LO_LSB    0
`define SPFS_FIELD_LO_MSB    1
`define SPFS_FIELD_HI_LSB    2
`define SPFS_FIELD_HI_MSB    3
`define SPFS_APPLIED_EN_BIT  8

// Reset values.
`define SPFS_RST_ENABLE      1'h0
`define SPFS_RST_SCALE       4'h0

// Scale codes and the divide ratios they select.
`define SPFS_CODE_DIV1       2'h0
`define SPFS_CODE_DIV4       2'h1
`define SPFS_CODE_DIV8       2'h2
`define SPFS_CODE_DIV16      2'h3
`define SPFS_RATIO_1         5'h01
`define SPFS_RATIO_4         5'h04
`define SPFS_RATIO_8         5'h08
`define SPFS_RATIO_16        5'h10

`endif

// [core/spfs_scale_div.v]
// One frequency scaler: divides a stream of single-cycle ticks by 1, 4, 8 or 16.
// Assumes tick_in is synchronous to clk and is at most one cycle wide per event.
`timescale 1ns/1ps
`include "spfs_defines.vh"

module spfs_scale_div (
  // Clock and reset.
  input  wire       clk,
  input  wire       rst_n,
  // Scale setting.
  input  wire [1:0] code,
  input  wire       apply,
  // Tick stream.
  input  wire       tick_in,
  output reg        tick_out,
  output reg  [4:0] ratio
);

  reg  [4:0] count;
  reg  [4:0] next_ratio;
  wire       setting_changed;

  // Selected ratio; a cleared apply forces divide-by-one.
  always @* begin
    if (!apply) begin
      next_ratio = `SPFS_RATIO_1;
    end else begin
      case (code)
        `SPFS_CODE_DIV4:  next_ratio = `SPFS_RATIO_4;
        `SPFS_CODE_DIV8:  next_ratio = `SPFS_RATIO_8;
        `SPFS_CODE_DIV16: next_ratio = `SPFS_RATIO_16;
        default:          next_ratio = `SPFS_RATIO_1;
      endcase
    end
  end

  // A new ratio restarts the count so no stretched period leaks through.
  // Only the ratio in force is compared, so code writes while apply is low cost no tick.
  assign setting_changed = (next_ratio != ratio);

  // Counts input ticks and emits one output tick per ratio input ticks.
  always @(posedge clk) begin
    if (!rst_n) begin
      count      <= 5'h00;
      tick_out   <= 1'b0;
      ratio      <= `SPFS_RATIO_1;
    end else begin
      ratio      <= next_ratio;
      if (setting_changed) begin
        count    <= 5'h00;
        tick_out <= 1'b0;
      end else if (tick_in) begin
        if (count >= next_ratio - 5'h01) begin
          count    <= 5'h00;
          tick_out <= 1'b1;
        end else begin
          count    <= count + 5'h01;
          tick_out <= 1'b0;
        end
      end else begin
        tick_out <= 1'b0;
      end
    end
  end

endmodule // spfs_scale_div

// [core/spfs_regs.v]
// Soft-pin frequency scale section: APB registers and the four scalers they steer.
// Assumes an APB master on clk, and tick inputs synchronous to clk.
`timescale 1ns/1ps
`include "spfs_defines.vh"

module spfs_regs (
  // Clock and reset.
  input  wire        clk,
  input  wire        rst_n,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Reference input ticks, one cycle per selected input period.
  input  wire        reference_input_first_tick,
  input  wire        reference_input_second_tick,
  // Channel divider ticks, one cycle per selected output period.
  input  wire        channel0_tick,
  input  wire        channel1_tick,
  // Scaled ticks.
  output wire        reference_input_first_scaled,
  output wire        reference_input_second_scaled,
  output wire        channel0_scaled,
  output wire        channel1_scaled,
  // Divide ratios in force, as plain binary.
  output wire [4:0]  reference_input_first_ratio,
  output wire [4:0]  reference_input_second_ratio,
  output wire [4:0]  channel0_ratio,
  output wire [4:0]  channel1_ratio,
  // Section state.
  output reg         section_applied
);

  // Scaler lane numbers inside the packed vectors.
  localparam LANE_REF_FIRST  = 0;
  localparam LANE_REF_SECOND = 1;
  localparam LANE_CH0        = 2;
  localparam LANE_CH1        = 3;
  localparam LANES           = 4;

  // Software-visible storage.
  reg        section_enable;
  reg  [3:0] reference_frequency_scale;
  reg  [3:0] output_frequency_scale;

  // Bus decode.
  wire        setup_phase;
  wire        access_done;
  wire        write_low_lane;
  wire        addr_is_enable;
  wire        addr_is_ref;
  wire        addr_is_out;
  wire        addr_is_applied;
  wire        addr_mapped;
  reg  [31:0] next_prdata;

  // Scaler lanes.
  wire [2*LANES-1:0] lane_code;
  wire [LANES-1:0]   lane_tick_in;
  wire [LANES-1:0]   lane_tick_out;
  wire [5*LANES-1:0] lane_ratio;

  // Applied codes, gated by the enable one cycle before the scalers see it.
  wire [3:0] applied_ref_scale;
  wire [3:0] applied_out_scale;

  // Setup cycle marks a new request; the access completes one cycle later.
  assign setup_phase    = psel && !penable;
  assign access_done    = psel && penable && pready;
  assign write_low_lane = access_done && pwrite && pstrb[0];

  // Register address decode on full byte addresses.
  assign addr_is_enable  = (paddr == `SPFS_ADDR_ENABLE);
  assign addr_is_ref     = (paddr == `SPFS_ADDR_REF_SCALE);
  assign addr_is_out     = (paddr == `SPFS_ADDR_OUT_SCALE);
  assign addr_is_applied = (paddr == `SPFS_ADDR_APPLIED);
  assign addr_mapped     = addr_is_enable || addr_is_ref || addr_is_out || addr_is_applied;

  // pready is raised for exactly the first access cycle, giving no wait states.
  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // Unmapped addresses and writes to the read-only status word answer with an error.
  always @(posedge clk) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= !addr_mapped || (pwrite && addr_is_applied);
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Enable register; only bit 0 is stored.
  always @(posedge clk) begin
    if (!rst_n) begin
      section_enable <= `SPFS_RST_ENABLE;
    end else if (write_low_lane && addr_is_enable) begin
      section_enable <= pwdata[`SPFS_ENABLE_BIT];
    end
  end

  // Reference scale register; the two fields share the low nibble.
  always @(posedge clk) begin
    if (!rst_n) begin
      reference_frequency_scale <= `SPFS_RST_SCALE;
    end else if (write_low_lane && addr_is_ref) begin
      reference_frequency_scale[`SPFS_FIELD_HI_MSB:`SPFS_FIELD_HI_LSB] <=
        pwdata[`SPFS_FIELD_HI_MSB:`SPFS_FIELD_HI_LSB];
      reference_frequency_scale[`SPFS_FIELD_LO_MSB:`SPFS_FIELD_LO_LSB] <=
        pwdata[`SPFS_FIELD_LO_MSB:`SPFS_FIELD_LO_LSB];
    end
  end

  // Output scale register for the two channel dividers.
  always @(posedge clk) begin
    if (!rst_n) begin
      output_frequency_scale <= `SPFS_RST_SCALE;
    end else if (write_low_lane && addr_is_out) begin
      output_frequency_scale[`SPFS_FIELD_HI_MSB:`SPFS_FIELD_HI_LSB] <=
        pwdata[`SPFS_FIELD_HI_MSB:`SPFS_FIELD_HI_LSB];
      output_frequency_scale[`SPFS_FIELD_LO_MSB:`SPFS_FIELD_LO_LSB] <=
        pwdata[`SPFS_FIELD_LO_MSB:`SPFS_FIELD_LO_LSB];
    end
  end

  // The fields only act while the section is enabled; otherwise all codes read divide-by-one.
  assign applied_ref_scale = section_enable ? reference_frequency_scale : `SPFS_RST_SCALE;
  assign applied_out_scale = section_enable ? output_frequency_scale : `SPFS_RST_SCALE;

  // Read data mux; reserved bits read as zero.
  always @* begin
    next_prdata = 32'h0000_0000;
    if (addr_is_enable) begin
      next_prdata[`SPFS_ENABLE_BIT] = section_enable;
    end else if (addr_is_ref) begin
      next_prdata[3:0] = reference_frequency_scale;
    end else if (addr_is_out) begin
      next_prdata[3:0] = output_frequency_scale;
    end else if (addr_is_applied) begin
      next_prdata[3:0]                  = applied_ref_scale;
      next_prdata[7:4]                  = applied_out_scale;
      next_prdata[`SPFS_APPLIED_EN_BIT] = section_applied;
    end
  end

  // Read data is captured in the setup cycle and held through the access cycle.
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= next_prdata;
    end else if (access_done) begin
      prdata <= 32'h0000_0000;
    end
  end

  // Registered copy of the enable, as seen by the scalers.
  always @(posedge clk) begin
    if (!rst_n) begin
      section_applied <= 1'b0;
    end else begin
      section_applied <= section_enable;
    end
  end

  // Lane codes: reference fields then channel fields, low field first.
  assign lane_code[2*LANE_REF_FIRST+1:2*LANE_REF_FIRST] =
    reference_frequency_scale[`SPFS_FIELD_LO_MSB:`SPFS_FIELD_LO_LSB];
  assign lane_code[2*LANE_REF_SECOND+1:2*LANE_REF_SECOND] =
    reference_frequency_scale[`SPFS_FIELD_HI_MSB:`SPFS_FIELD_HI_LSB];
  assign lane_code[2*LANE_CH0+1:2*LANE_CH0] =
    output_frequency_scale[`SPFS_FIELD_LO_MSB:`SPFS_FIELD_LO_LSB];
  assign lane_code[2*LANE_CH1+1:2*LANE_CH1] =
    output_frequency_scale[`SPFS_FIELD_HI_MSB:`SPFS_FIELD_HI_LSB];

  // Lane tick inputs in the same order.
  assign lane_tick_in[LANE_REF_FIRST]  = reference_input_first_tick;
  assign lane_tick_in[LANE_REF_SECOND] = reference_input_second_tick;
  assign lane_tick_in[LANE_CH0]        = channel0_tick;
  assign lane_tick_in[LANE_CH1]        = channel1_tick;

  // One scaler per lane; each forces divide-by-one while the section is off.
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
      spfs_scale_div u_div (
        .clk      (clk),
        .rst_n    (rst_n),
        .code     (lane_code[2*lane+1:2*lane]),
        .apply    (section_applied),
        .tick_in  (lane_tick_in[lane]),
        .tick_out (lane_tick_out[lane]),
        .ratio    (lane_ratio[5*lane+4:5*lane])
      );
    end
  endgenerate

  // Scaled ticks, each straight from its scaler's output flop.
  assign reference_input_first_scaled  = lane_tick_out[LANE_REF_FIRST];
  assign reference_input_second_scaled = lane_tick_out[LANE_REF_SECOND];
  assign channel0_scaled               = lane_tick_out[LANE_CH0];
  assign channel1_scaled               = lane_tick_out[LANE_CH1];

  // Ratios in force, each straight from its scaler's ratio flop.
  assign reference_input_first_ratio  = lane_ratio[5*LANE_REF_FIRST+4:5*LANE_REF_FIRST];
  assign reference_input_second_ratio = lane_ratio[5*LANE_REF_SECOND+4:5*LANE_REF_SECOND];
  assign channel0_ratio               = lane_ratio[5*LANE_CH0+4:5*LANE_CH0];
  assign channel1_ratio               = lane_ratio[5*LANE_CH1+4:5*LANE_CH1];

endmodule // spfs_regs

// [verification/spfs_regs_chk.sv]
// Checker for the soft-pin frequency scale section, bound to spfs_regs.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module spfs_regs_chk (
  // Clock, reset and bus answer.
  input logic       clk,
  input logic       rst_n,
  input logic       psel,
  input logic       penable,
  input logic       pready,
  input logic       pslverr,
  // Ticks in and out.
  input logic       reference_input_first_tick,
  input logic       reference_input_first_scaled,
  input logic       channel0_tick,
  input logic       channel0_scaled,
  input logic       channel1_tick,
  input logic       channel1_scaled,
  // Ratios and section state.
  input logic [4:0] reference_input_first_ratio,
  input logic [4:0] reference_input_second_ratio,
  input logic [4:0] channel0_ratio,
  input logic [4:0] channel1_ratio,
  input logic       section_applied
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Channel zero settled at ratio one, so no count restart is pending.
  sequence s_steady0;
    (channel0_ratio == 5'h01 && $stable(section_applied))[*4];
  endsequence
  // The section has been off for two cycles.
  sequence s_off2;
    !section_applied ##1 !section_applied;
  endsequence
  a_pass_ch0: assert property (
    s_steady0 ##0 channel0_tick ##1 (channel0_ratio == 5'h01) |-> channel0_scaled)
    else $error("Tick lost at ratio one.");
  a_off_unity: assert property (
    s_off2 |-> {reference_input_first_ratio, reference_input_second_ratio,
                channel0_ratio, channel1_ratio} == 20'h0_8421) else $error("Ratio not one.");
  a_ratio_code: assert property (
    reference_input_second_ratio inside {5'h01, 5'h04, 5'h08, 5'h10})
    else $error("Illegal ratio.");
  a_first_cause: assert property (
    reference_input_first_scaled |-> $past(reference_input_first_tick))
    else $error("Spurious scaled tick.");
  a_ch1_cause: assert property (
    channel1_scaled |-> $past(channel1_tick)) else $error("Spurious channel tick.");
  a_ratio_gate: assert property (
    channel1_ratio != 5'h01 |-> $past(section_applied)) else $error("Ratio while off.");
  a_ready_next: assert property (
    psel && !penable |=> pready) else $error("Late bus answer.");
  a_err_ready: assert property (
    pslverr |-> pready) else $error("Error without ready.");
endmodule // spfs_regs_chk

bind spfs_regs spfs_regs_chk chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .section_applied(section_applied),
  .reference_input_first_tick(reference_input_first_tick),
  .reference_input_first_scaled(reference_input_first_scaled),
  .channel0_tick(channel0_tick), .channel0_scaled(channel0_scaled),
  .channel1_tick(channel1_tick), .channel1_scaled(channel1_scaled),
  .reference_input_first_ratio(reference_input_first_ratio),
  .reference_input_second_ratio(reference_input_second_ratio),
  .channel0_ratio(channel0_ratio), .channel1_ratio(channel1_ratio));

// [verification/spfs_regs_tb.sv]
// Self-checking bench for the soft-pin frequency scale section.
// Assumes spfs_regs and its bound checker are compiled before it.
`timescale 1ns/1ps
`include "spfs_defines.vh"
module spfs_regs_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, applied, serr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb, tick;
  wire  [3:0]  scaled;
  wire  [4:0]  r [0:3];
  int          err_count, checked, cnt [4];
  // Rows: reference and output scale nibbles, then ratios first, second, ch0, ch1.
  logic [7:0]  rin [4] = '{8'h4B, 8'hB4, 8'hE1, 8'h1E};
  logic [19:0] rexp [4] = '{20'h0_9208, 20'h8_2024, 20'h4_4081, 20'h2_0510};

  spfs_regs dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .section_applied(applied),
    .reference_input_first_tick(tick[0]), .reference_input_second_tick(tick[1]),
    .channel0_tick(tick[2]), .channel1_tick(tick[3]),
    .reference_input_first_scaled(scaled[0]), .reference_input_second_scaled(scaled[1]),
    .channel0_scaled(scaled[2]), .channel1_scaled(scaled[3]),
    .reference_input_first_ratio(r[0]), .reference_input_second_ratio(r[1]),
    .channel0_ratio(r[2]), .channel1_ratio(r[3]));

  // Free-running 250 MHz clock.
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end

  // Compares one value and counts the outcome.
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    // Waits for the answer however long it takes; only the watchdog ends a hang.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // Counts scaled pulses over 160 cycles of back-to-back ticks.
  task count_pulses();
    cnt = '{0, 0, 0, 0};
    repeat (160) begin
      @(negedge clk);
      for (int i = 0; i < 4; i++) cnt[i] += scaled[i];
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task end_sim();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #100000;
    err_count++;
    end_sim();
  end

  // Main sequence: table rows, then the off state, refusals and a second reset.
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb, tick} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    apb(1, `SPFS_ADDR_ENABLE, 32'h0000_0001, 4'h1);
    tick <= 4'hF;
    for (int k = 0; k < 4; k++) begin
      apb(1, `SPFS_ADDR_REF_SCALE, rin[k][7:4], 4'h1);
      apb(1, `SPFS_ADDR_OUT_SCALE, rin[k][3:0], 4'h1);
      repeat (4) @(posedge clk);
      chk("ratios", rexp[k], {r[0], r[1], r[2], r[3]});
      count_pulses();
      for (int i = 0; i < 4; i++) chk("pulses", 160 / rexp[k][19-5*i -: 5], cnt[i]);
      apb(0, `SPFS_ADDR_REF_SCALE, 0, 4'h0);
      chk("ref readback", rin[k][7:4], rdat);
    end
    chk("applied pin", 1, applied);
    apb(0, `SPFS_ADDR_APPLIED, 0, 4'h0);
    chk("applied reg", 32'h0000_01E1, rdat);
    apb(1, `SPFS_ADDR_ENABLE, 32'h0000_0000, 4'h1);
    repeat (4) @(posedge clk);
    chk("off applied", 0, applied);
    chk("off ratios", 20'h0_8421, {r[0], r[1], r[2], r[3]});
    count_pulses();
    for (int i = 0; i < 4; i++) chk("off pulses", 160, cnt[i]);
    apb(1, `SPFS_ADDR_OUT_SCALE, 0, 4'h0);
    apb(0, `SPFS_ADDR_OUT_SCALE, 0, 4'h0);
    chk("kept field", 32'h0000_000E, rdat);
    apb(0, 16'h3018, 0, 4'h0);
    chk("unmapped", 32'h0000_0001, {rdat[30:0], serr});
    apb(1, `SPFS_ADDR_APPLIED, 32'h0000_0001, 4'h1);
    chk("ro write err", 1, serr);
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    apb(0, `SPFS_ADDR_OUT_SCALE, 0, 4'h0);
    chk("reset field", 0, rdat);
    chk("reset state", 32'h0000_8421, {applied, r[0], r[1], r[2], r[3]});
    end_sim();
  end
endmodule // spfs_regs_tb
